// ===== rtl/asp_cfg.svh
// constants of the converter serial port: register offsets, field positions, timing counts
// assumes inclusion by the package and the testbench only
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
// register byte offsets on the axi4-lite bus
`define ASP_OFS_CTRL 8'h00
`define ASP_OFS_DATA 8'h04
`define ASP_OFS_FLAGS 8'h08
`define ASP_OFS_STATUS 8'h0C
`define ASP_OFS_CFG_RX 8'h10
`define ASP_OFS_IRQ_STAT 8'h14
`define ASP_OFS_IRQ_MASK 8'h18
// control fields
`define ASP_CTRL_EN 0
`define ASP_CTRL_DEC32 1
`define ASP_CTRL_ADR_LO 2
`define ASP_CTRL_ADR_HI 4
`define ASP_CTRL_RST 5'h00
// interrupt bits
`define ASP_IRQ_TX_DONE 0
`define ASP_IRQ_RX_DONE 1
`define ASP_IRQ_OVERRUN 2
// shift clock half periods in aclk cycles, minus one
`define ASP_HALF_FAST 4'h3
`define ASP_HALF_SLOW 4'h7
// word framing
`define ASP_LAST_BIT 6'h1F
`define ASP_FIRST_RX 6'h01
// axi responses
`define ASP_RESP_OKAY 2'h0
`define ASP_RESP_SLVERR 2'h2
`endif

// ===== rtl/asp_pkg.sv
// types of the converter serial port
// assumes asp_cfg.svh sits beside it
package asp_pkg;
  `include "asp_cfg.svh"
  // synchronised pin group
  typedef struct packed {
    logic i2s_select;
    logic shift_edge_polarity;
    logic shift_rate_select;
    logic clock_divide_select;
    logic frame_in_strobe;
    logic serial_in_line;
  } asp_pins_t;
  // transmit sequencer, one-hot
  typedef enum logic [1:0] {
    ASP_TX_IDLE = 2'b01,
    ASP_TX_SHIFT = 2'b10
  } asp_tx_state_t;
  // register select
  typedef enum logic [2:0] {
    ASP_SEL_NONE = 3'h0,
    ASP_SEL_CTRL = 3'h1,
    ASP_SEL_DATA = 3'h2,
    ASP_SEL_FLAGS = 3'h3,
    ASP_SEL_STATUS = 3'h4,
    ASP_SEL_CFG_RX = 3'h5,
    ASP_SEL_IRQ_STAT = 3'h6,
    ASP_SEL_IRQ_MASK = 3'h7
  } asp_sel_t;
endpackage

// ===== rtl/asp_serial_port.sv
// serial port of a sigma-delta converter: config word receiver, result word transmitter,
// shift clock divider, i2s output switch, axi4-lite registers and interrupt
// assumes pins arrive asynchronously; aclk stands for the master clock
//
// Overview of operation
// (R1) host puts write msb on next active edge after frame-in latched
// (R2) config write is 32 bits: broadcast, 3 device, 12 register, 16 data
// (R3) polarity 0: output bit launched on rising shift clock edge
// (R4) serial output carries data, address and status bits each transfer
// (R5) shift clock derived from internal clock, equal to it or half
// (R6) frame output low for 32 shift clock periods per word
// (R7) decimate-by-32 with some pin settings holds frame output low
// (R8) divide select pin sets master to internal clock ratio
// (R9) i2s select high turns outputs into sd, sck and ws
// (R10) host keeps i2s select low while writing config words
// (R11) frame-in sampled on falling edge; first bit on next edge
// (R12) polarity 1 inverts every shift clock edge
// (R13) divide by 1 or 2; shift rate pin doubles clock in divide-by-2
// (R14) word is 24 data bits then 7 status bits over 32 cycles
// (R15) serial input ignored unless a frame-in event was latched
`timescale 1ns/1ps
module asp_serial_port
  import asp_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // mode pins
  input wire logic clock_divide_select,
  input wire logic shift_rate_select,
  input wire logic shift_edge_polarity,
  input wire logic i2s_select,
  // serial link
  input wire logic frame_in_strobe,
  input wire logic serial_in_line,
  output logic shift_clock_out,
  output logic frame_out_strobe,
  output logic serial_out_line,
  output logic serial_out_line_oe,
  // interrupt
  output logic irq
);

  function automatic asp_sel_t reg_sel(input logic [7:0] a);
    if (a == `ASP_OFS_CTRL) reg_sel = ASP_SEL_CTRL;
    else if (a == `ASP_OFS_DATA) reg_sel = ASP_SEL_DATA;
    else if (a == `ASP_OFS_FLAGS) reg_sel = ASP_SEL_FLAGS;
    else if (a == `ASP_OFS_STATUS) reg_sel = ASP_SEL_STATUS;
    else if (a == `ASP_OFS_CFG_RX) reg_sel = ASP_SEL_CFG_RX;
    else if (a == `ASP_OFS_IRQ_STAT) reg_sel = ASP_SEL_IRQ_STAT;
    else if (a == `ASP_OFS_IRQ_MASK) reg_sel = ASP_SEL_IRQ_MASK;
    else reg_sel = ASP_SEL_NONE;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // pin synchronisers: a change counts once stages two and three agree
  logic [5:0] pin_raw, s1_r, s2_r, s3_r, pin_r, pin_nxt;
  asp_pins_t pins;
  assign pin_raw = {i2s_select, shift_edge_polarity, shift_rate_select,
                    clock_divide_select, frame_in_strobe, serial_in_line};
  for (genvar g = 0; g < 6; g++) begin : g_sync
    always_comb begin
      pin_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : pin_r[g];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
      s3_r <= 6'h00;
      pin_r <= 6'h00;
    end else begin
      s1_r <= pin_raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pin_r <= pin_nxt;
    end
  end
  assign pins = asp_pins_t'(pin_r);

  // software state
  logic [4:0] ctrl_r, ctrl_nxt;
  logic [23:0] data_r, data_nxt;
  logic [3:0] flags_r, flags_nxt;
  logic pending_r, pending_nxt;
  logic [31:0] cfg_rx_r, cfg_rx_nxt;
  logic [2:0] irq_stat_r, irq_stat_nxt, irq_mask_r, irq_mask_nxt, irq_set;
  // link state
  logic sclk_r, sclk_nxt;
  logic [3:0] hcnt_r, hcnt_nxt;
  asp_tx_state_t tx_state_r, tx_state_nxt;
  logic [5:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
  logic [30:0] tx_sh_r, tx_sh_nxt;
  logic sd_dly_r, sd_dly_nxt;
  logic rx_armed_r, rx_armed_nxt, rx_busy_r, rx_busy_nxt;
  logic [31:0] rx_sh_r, rx_sh_nxt;
  // bus state
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;

  logic fast, rise_ev, fall_ev, tx_start, tx_done, rx_done, cont_low, tx_shift, cfg_hit;
  logic wr_fire, rd_fire;
  asp_sel_t wsel, rsel;

  assign fast = pins.clock_divide_select | pins.shift_rate_select; // R5 R8 R13
  assign rise_ev = (hcnt_r == 4'h0) && !sclk_r;
  assign fall_ev = (hcnt_r == 4'h0) && sclk_r;
  assign tx_shift = (tx_state_r == ASP_TX_SHIFT);
  assign tx_start = rise_ev && !tx_shift && pending_r && ctrl_r[`ASP_CTRL_EN];
  assign tx_done = rise_ev && tx_shift && (tx_cnt_r == `ASP_LAST_BIT);
  assign rx_done = fall_ev && rx_busy_r && (rx_cnt_r == `ASP_LAST_BIT);
  // decimate-by-32: only divide-by-2 with fast rate leaves room to pulse the frame
  assign cont_low = ctrl_r[`ASP_CTRL_DEC32] &&
                    !(!pins.clock_divide_select && pins.shift_rate_select); // R7
  // broadcast or matching device address
  assign cfg_hit = cfg_rx_r[31] || // R2
                   (cfg_rx_r[30:28] == ctrl_r[`ASP_CTRL_ADR_HI:`ASP_CTRL_ADR_LO]);

  // link: shift clock divider, transmitter, receiver
  always_comb begin
    sclk_nxt = sclk_r;
    hcnt_nxt = hcnt_r - 4'h1;
    tx_state_nxt = tx_state_r;
    tx_cnt_nxt = tx_cnt_r;
    tx_sh_nxt = tx_sh_r;
    sd_dly_nxt = sd_dly_r;
    rx_armed_nxt = rx_armed_r;
    rx_busy_nxt = rx_busy_r;
    rx_cnt_nxt = rx_cnt_r;
    rx_sh_nxt = rx_sh_r;
    if (hcnt_r == 4'h0) begin
      sclk_nxt = !sclk_r;
      hcnt_nxt = fast ? `ASP_HALF_FAST : `ASP_HALF_SLOW; // R5 R13
    end
    if (rise_ev) begin
      sd_dly_nxt = tx_shift ? tx_sh_r[30] : 1'b0;
      case (tx_state_r)
        ASP_TX_IDLE: begin
          if (tx_start) begin
            tx_state_nxt = ASP_TX_SHIFT;
            tx_cnt_nxt = 6'h00;
            tx_sh_nxt = {data_r, ctrl_r[`ASP_CTRL_ADR_HI:`ASP_CTRL_ADR_LO], flags_r}; // R14 R4
          end
        end
        ASP_TX_SHIFT: begin
          if (tx_cnt_r == `ASP_LAST_BIT) begin
            tx_state_nxt = ASP_TX_IDLE; // R6
          end else begin
            tx_cnt_nxt = tx_cnt_r + 6'h01;
            tx_sh_nxt = {tx_sh_r[29:0], 1'b0}; // R3
          end
        end
        default: tx_state_nxt = ASP_TX_IDLE;
      endcase
    end
    if (fall_ev) begin
      if (rx_busy_r) begin
        rx_sh_nxt = {rx_sh_r[30:0], pins.serial_in_line}; // R2
        rx_cnt_nxt = rx_cnt_r + 6'h01;
        if (rx_cnt_r == `ASP_LAST_BIT) begin
          rx_busy_nxt = 1'b0;
        end
      end else if (rx_armed_r) begin
        rx_armed_nxt = 1'b0;
        rx_busy_nxt = 1'b1;
        rx_cnt_nxt = `ASP_FIRST_RX;
        rx_sh_nxt = {31'h0000_0000, pins.serial_in_line}; // R11 R1
      end else if (!pins.frame_in_strobe && !pins.i2s_select && ctrl_r[`ASP_CTRL_EN]) begin
        rx_armed_nxt = 1'b1; // R11 R15 R10
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_r <= 1'b0;
      hcnt_r <= `ASP_HALF_SLOW;
      tx_state_r <= ASP_TX_IDLE;
      tx_cnt_r <= 6'h00;
      tx_sh_r <= 31'h0000_0000;
      sd_dly_r <= 1'b0;
      rx_armed_r <= 1'b0;
      rx_busy_r <= 1'b0;
      rx_cnt_r <= 6'h00;
      rx_sh_r <= 32'h0000_0000;
    end else begin
      sclk_r <= sclk_nxt;
      hcnt_r <= hcnt_nxt;
      tx_state_r <= tx_state_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      tx_sh_r <= tx_sh_nxt;
      sd_dly_r <= sd_dly_nxt;
      rx_armed_r <= rx_armed_nxt;
      rx_busy_r <= rx_busy_nxt;
      rx_cnt_r <= rx_cnt_nxt;
      rx_sh_r <= rx_sh_nxt;
    end
  end

  // pin outputs; i2s moves launches to the falling sck edge and delays sd one bit
  assign shift_clock_out = pins.i2s_select ? !sclk_r : // R12 R9
                           (sclk_r ^ pins.shift_edge_polarity);
  assign frame_out_strobe = !(tx_shift || (cont_low && !pins.i2s_select)); // R6 R7 R9
  assign serial_out_line = pins.i2s_select ? sd_dly_r : tx_sh_r[30]; // R9 R4
  assign serial_out_line_oe = pins.i2s_select || (tx_shift && tx_cnt_r != `ASP_LAST_BIT); // R14

  // axi4-lite slave and registers
  assign awready = !aw_got_r && !bvalid_r;
  assign wready = !w_got_r && !bvalid_r;
  assign arready = !rvalid_r;
  assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
  assign rd_fire = arvalid && arready;
  assign wsel = reg_sel(awaddr_r);
  assign rsel = reg_sel(araddr);

  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    aw_got_nxt = aw_got_r;
    w_got_nxt = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    ctrl_nxt = ctrl_r;
    data_nxt = data_r;
    flags_nxt = flags_r;
    pending_nxt = pending_r;
    cfg_rx_nxt = cfg_rx_r;
    irq_mask_nxt = irq_mask_r;
    irq_set = {pending_r && !tx_start && wr_fire && wsel == ASP_SEL_DATA, rx_done, tx_done};
    irq_stat_nxt = irq_stat_r;
    if (awvalid && awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    if (tx_start) begin
      pending_nxt = 1'b0;
    end
    if (rx_done) begin
      cfg_rx_nxt = {rx_sh_r[30:0], pins.serial_in_line}; // R2
    end
    if (wr_fire) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = `ASP_RESP_OKAY;
      m = merge(32'h0000_0000, wdata_r, wstrb_r);
      if (wsel == ASP_SEL_CTRL) begin
        m = merge({27'h000_0000, ctrl_r}, wdata_r, wstrb_r);
        ctrl_nxt = m[4:0];
      end else if (wsel == ASP_SEL_DATA) begin
        m = merge({8'h00, data_r}, wdata_r, wstrb_r);
        data_nxt = m[23:0];
        pending_nxt = 1'b1;
      end else if (wsel == ASP_SEL_FLAGS) begin
        m = merge({28'h000_0000, flags_r}, wdata_r, wstrb_r);
        flags_nxt = m[3:0];
      end else if (wsel == ASP_SEL_IRQ_STAT) begin
        irq_stat_nxt = irq_stat_r & ~m[2:0];
      end else if (wsel == ASP_SEL_IRQ_MASK) begin
        irq_mask_nxt = m[2:0];
      end else if (wsel == ASP_SEL_NONE) begin
        bresp_nxt = `ASP_RESP_SLVERR;
      end
    end
    // a new event wins over a clear in the same cycle
    irq_stat_nxt = irq_stat_nxt | irq_set;
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end
    if (rd_fire) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = `ASP_RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      if (rsel == ASP_SEL_CTRL) rdata_nxt[4:0] = ctrl_r;
      else if (rsel == ASP_SEL_DATA) rdata_nxt[23:0] = data_r;
      else if (rsel == ASP_SEL_FLAGS) rdata_nxt[3:0] = flags_r;
      else if (rsel == ASP_SEL_STATUS) rdata_nxt[10:0] = {cont_low, cfg_hit, rx_busy_r,
                                                         pending_r, tx_shift, pin_r};
      else if (rsel == ASP_SEL_CFG_RX) rdata_nxt = cfg_rx_r;
      else if (rsel == ASP_SEL_IRQ_STAT) rdata_nxt[2:0] = irq_stat_r;
      else if (rsel == ASP_SEL_IRQ_MASK) rdata_nxt[2:0] = irq_mask_r;
      else rresp_nxt = `ASP_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `ASP_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `ASP_RESP_OKAY;
      ctrl_r <= `ASP_CTRL_RST;
      data_r <= 24'h00_0000;
      flags_r <= 4'h0;
      pending_r <= 1'b0;
      cfg_rx_r <= 32'h0000_0000;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
    end else begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      ctrl_r <= ctrl_nxt;
      data_r <= data_nxt;
      flags_r <= flags_nxt;
      pending_r <= pending_nxt;
      cfg_rx_r <= cfg_rx_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
    end
  end

  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign irq = |(irq_stat_r & irq_mask_r);

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  frame_start_a: assert property (tx_start |=> tx_shift && tx_cnt_r == 6'h00) // R6
    else $error("frame did not open on start");
  frame_end_a: assert property (tx_done |=> !tx_shift) // R6
    else $error("frame did not close after 32 periods");
  last_bit_a: assert property (tx_shift && tx_cnt_r == `ASP_LAST_BIT && // R14
    !pins.i2s_select |-> !serial_out_line_oe)
    else $error("output driven in final period");
  launch_edge_a: assert property (tx_shift && $changed(tx_sh_r) |-> $past(rise_ev)) // R3
    else $error("bit launched off the rising edge");
  clock_rate_a: assert property (rise_ev |=> !rise_ev [*7]) // R5
    else $error("shift clock faster than allowed");
  rx_first_a: assert property (rx_armed_r && fall_ev |=> rx_busy_r && rx_cnt_r == 6'h01) // R11
    else $error("first write bit not taken");
  rx_ignore_a: assert property (!rx_armed_r && !rx_busy_r |=> !rx_busy_r) // R15
    else $error("receiver started without frame-in");
  rx_word_a: assert property (rx_done |=> // R2
    cfg_rx_r == {$past(rx_sh_r[30:0]), $past(pins.serial_in_line)})
    else $error("config word stored wrongly");
  cont_low_a: assert property (ctrl_r[`ASP_CTRL_DEC32] && !pins.i2s_select && // R7
    (pins.clock_divide_select || !pins.shift_rate_select) |-> !frame_out_strobe)
    else $error("frame output not held low");
  word_sent_c: cover property (tx_done);
  word_recv_c: cover property (rx_done);
  cont_frame_c: cover property (cont_low && tx_shift);

endmodule // asp_serial_port

// ===== tb/asp_host_model.sv
// host controller model for the converter serial port: writes config words, captures result words
// assumes the shift clock runs freely and polarity stays steady during a transfer
`timescale 1ns/1ps
module asp_host_model (
  // device pins
  input wire logic shift_clock_out,
  input wire logic frame_out_strobe,
  input wire logic serial_out_line,
  input wire logic shift_edge_polarity,
  output logic frame_in_strobe,
  output logic serial_in_line,
  // bench side
  input wire logic cap_en,
  output logic [30:0] got_word,
  output logic [5:0] got_len,
  output logic got_tgl
);
  initial begin
    frame_in_strobe = 1'b1;
    serial_in_line = 1'b0;
    got_word = '0;
    got_len = '0;
    got_tgl = 1'b0;
  end

  // device samples on this edge; host changes just after it
  task automatic act_edge;
    if (shift_edge_polarity) @(posedge shift_clock_out);
    else @(negedge shift_clock_out);
  endtask

  // frame low for one period, msb valid on the next active edge, 32 bits in all
  task automatic send_word(input logic [31:0] w, input logic framed);
    act_edge();
    frame_in_strobe <= ~framed;
    act_edge();
    frame_in_strobe <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      serial_in_line <= w[i];
      act_edge();
    end
    // released line shows the inverse of the last bit
    serial_in_line <= ~w[0];
  endtask

  // sample each bit on the edge after its launch; count periods while the frame is low
  always @(negedge frame_out_strobe) begin
    logic [30:0] w;
    int n;
    if (cap_en) begin
      n = 0;
      w = '0;
      act_edge();
      while (!frame_out_strobe && n < 40) begin
        if (n < 31) w = {w[29:0], serial_out_line};
        n++;
        act_edge();
      end
      got_word <= w;
      got_len <= 6'(n);
      got_tgl <= ~got_tgl;
    end
  end
endmodule // asp_host_model

// ===== tb/tb_top.sv
// self-checking bench of the converter serial port over axi4-lite and the serial pins
// assumes asp_cfg.svh is on the include path and the host model stands beside the design
`timescale 1ns/1ps
`include "asp_cfg.svh"
module tb_top;
  logic aclk = 1'b0;
  logic aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic div, rate, pol, i2s, frame_in_strobe, serial_in_line, cap_en, irq;
  logic shift_clock_out, frame_out_strobe, serial_out_line, serial_out_line_oe, got_tgl;
  logic [30:0] got_word;
  logic [5:0] got_len;
  logic [39:0] exp_q[$];
  int fail_count = 0;
  int num_checks = 0;

  always #12.5 aclk = ~aclk;

  asp_serial_port dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .clock_divide_select(div), .shift_rate_select(rate),
    .shift_edge_polarity(pol), .i2s_select(i2s), .frame_in_strobe(frame_in_strobe),
    .serial_in_line(serial_in_line), .shift_clock_out(shift_clock_out),
    .frame_out_strobe(frame_out_strobe), .serial_out_line(serial_out_line),
    .serial_out_line_oe(serial_out_line_oe), .irq(irq));

  asp_host_model host_u (.shift_clock_out(shift_clock_out), .frame_out_strobe(frame_out_strobe),
    .serial_out_line(serial_out_line), .shift_edge_polarity(pol),
    .frame_in_strobe(frame_in_strobe), .serial_in_line(serial_in_line), .cap_en(cap_en),
    .got_word(got_word), .got_len(got_len), .got_tgl(got_tgl));

  task check(input string what, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task give_up(input string what);
    fail_count++;
    $display("CHECK FAILED %s expected answer seen timeout", what);
    finish_test();
  endtask

  task pop_cmp(input string what, input logic [39:0] seen);
    logic [39:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : ~seen;
    check(what, seen, e);
  endtask

  // watcher: each result takes the oldest note
  always @(posedge aclk) if (rvalid && rready) pop_cmp("read data", {6'h0, rresp, rdata});
  always @(got_tgl) if ($time > 0) pop_cmp("sent word", {got_len, 3'h0, got_word});

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ag, wg, bg;
    logic [1:0] r;
    n = 0;
    bg = 1'b0;
    r = 2'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bg) begin
      @(negedge aclk);
      ag = awvalid && awready;
      wg = wvalid && wready;
      bg = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (ag) awvalid <= 1'b0;
      if (wg) wvalid <= 1'b0;
      n++;
      if (n > 50) give_up("write response");
    end
    // bready stays high so that a following call never re-drives it in the same step
    check("write response", {38'h0, r}, {38'h0, er});
  endtask

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ag, rg;
    n = 0;
    rg = 1'b0;
    exp_q.push_back({6'h0, er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rg) begin
      @(negedge aclk);
      ag = arvalid && arready;
      rg = rvalid && rready;
      @(posedge aclk);
      if (ag) arvalid <= 1'b0;
      n++;
      if (n > 50) give_up("read data");
    end
  endtask

  task sck_period(output int p);
    int seen;
    logic prev;
    seen = 0;
    p = 0;
    prev = shift_clock_out;
    for (int n = 0; n < 100 && seen < 2; n++) begin
      @(posedge aclk);
      if (shift_clock_out && !prev) seen++;
      if (seen == 1) p++;
      prev = shift_clock_out;
    end
  endtask

  task check_irq(input logic e);
    repeat (2) @(posedge aclk);
    check("irq", {39'h0, irq}, {39'h0, e});
  endtask

  initial begin
    repeat (100000) @(posedge aclk);
    give_up("whole run");
  end

  initial begin
    logic [23:0] dat;
    logic [3:0] flg;
    logic [2:0] adr;
    logic [31:0] cw;
    int p;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    {div, rate, pol, i2s} = '0;
    cap_en = 1'b1;
    p = $urandom(32'h4535);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h1c, 32'h0, `ASP_RESP_SLVERR);
    wr(8'h1c, 32'h0, `ASP_RESP_SLVERR);
    // shift clock period for every divide and rate setting
    for (int m = 0; m < 4; m++) begin
      {div, rate} <= 2'(m);
      repeat (12) @(posedge aclk);
      sck_period(p);
      check("shift period", 40'(p), (m == 0) ? 40'd16 : 40'd8);
    end
    {div, rate} <= 2'h0;
    // result words with both polarities
    for (int k = 0; k < 2; k++) begin
      pol <= k[0];
      adr = 3'($urandom);
      flg = 4'($urandom);
      dat = 24'($urandom);
      repeat (10) @(posedge aclk);
      wr(`ASP_OFS_CTRL, {27'h0, adr, 2'b01}, `ASP_RESP_OKAY);
      wr(`ASP_OFS_FLAGS, {28'h0, flg}, `ASP_RESP_OKAY);
      wr(`ASP_OFS_IRQ_MASK, 32'h1, `ASP_RESP_OKAY);
      exp_q.push_back({6'd32, 3'h0, dat, adr, flg});
      wr(`ASP_OFS_DATA, {8'h0, dat}, `ASP_RESP_OKAY);
      for (p = 0; p < 3000 && exp_q.size() > 0; p++) @(posedge aclk);
      if (exp_q.size() > 0) give_up("sent word");
      check_irq(1'b1);
      wr(`ASP_OFS_IRQ_STAT, 32'h1, `ASP_RESP_OKAY);
      check_irq(1'b0);
    end
    // config word with inverted edges, then unframed activity that must be ignored
    cw = $urandom;
    host_u.send_word(cw, 1'b1);
    host_u.send_word(~cw, 1'b0);
    @(posedge aclk);
    rd(`ASP_OFS_CFG_RX, cw, `ASP_RESP_OKAY);
    rd(`ASP_OFS_IRQ_STAT, 32'h2, `ASP_RESP_OKAY);
    check_irq(1'b0);
    wr(`ASP_OFS_IRQ_MASK, 32'h2, `ASP_RESP_OKAY);
    check_irq(1'b1);
    wr(`ASP_OFS_IRQ_STAT, 32'h2, `ASP_RESP_OKAY);
    check_irq(1'b0);
    // decimate-by-32: frame held low except with divide 0 and rate 1
    cap_en <= 1'b0;
    {div, rate} <= 2'b10;
    wr(`ASP_OFS_CTRL, {27'h0, adr, 2'b11}, `ASP_RESP_OKAY);
    repeat (40) @(posedge aclk);
    check("frame held", {39'h0, frame_out_strobe}, 40'h0);
    {div, rate} <= 2'b01;
    repeat (40) @(posedge aclk);
    check("frame idle", {39'h0, frame_out_strobe}, 40'h1);
    // i2s output path drives the data line
    wr(`ASP_OFS_CTRL, {27'h0, adr, 2'b01}, `ASP_RESP_OKAY);
    i2s <= 1'b1;
    repeat (20) @(posedge aclk);
    check("i2s drive", {39'h0, serial_out_line_oe}, 40'h1);
    finish_test();
  end
endmodule // tb_top
